// [core/rsse_pkg.sv]
package rsse_pkg;

    // Datapath width and fixed byte values.
    localparam int          RSSE_BYTE_W     = 8;
    localparam int          RSSE_NIB_W      = 4;
    localparam logic [7:0]  RSSE_ALL_ONES   = 8'hFF;
    localparam logic [7:0]  RSSE_ZERO_BYTE  = 8'h00;
    localparam logic [7:0]  RSSE_ONE        = 8'h01;

    // Reset values of the work register, flags and interrupt gate.
    localparam logic [7:0]  RSSE_WORK_RESET = 8'h00;
    localparam logic        RSSE_FLAG_RESET = 1'b0;
    localparam logic        RSSE_GATE_RESET = 1'b0;

    // Instructions executed by this block.
    typedef enum logic [4:0] {
        OP_NOP,
        OP_POP_LOAD_LITERAL,
        OP_IRQ_EXIT,
        OP_ROTATE_LEFT,
        OP_ROTATE_LEFT_TO_WORK,
        OP_ROTATE_LEFT_THROUGH_FLAG,
        OP_ROTATE_LEFT_THROUGH_FLAG_TO_WORK,
        OP_ROTATE_RIGHT,
        OP_ROTATE_RIGHT_TO_WORK,
        OP_ROTATE_RIGHT_THROUGH_FLAG,
        OP_ROTATE_RIGHT_THROUGH_FLAG_TO_WORK,
        OP_MINUS_WITH_BORROW,
        OP_MINUS_WITH_BORROW_TO_MEMORY,
        OP_MINUS,
        OP_MINUS_TO_MEMORY,
        OP_MINUS_LITERAL,
        OP_DECREMENT_SKIP_ZERO,
        OP_DECREMENT_SKIP_ZERO_TO_WORK,
        OP_INCREMENT_SKIP_ZERO,
        OP_INCREMENT_SKIP_ZERO_TO_WORK,
        OP_SKIP_BIT_HIGH,
        OP_SET_BYTE,
        OP_SET_BIT
    } rsse_op_e;

    // Execution phase: a skip instruction holds a dummy slot.
    typedef enum logic {
        PH_RUN,
        PH_DUMMY
    } rsse_phase_e;

endpackage

// [core/rsse_rotator.sv]
`timescale 1ns/10ps
module rsse_rotator (
    // Operand
    input  wire logic [7:0] data_in,
    input  wire logic       carry_in,
    // Mode
    input  wire logic       dir_right,
    input  wire logic       through,
    // Result
    output logic [7:0]      data_out,
    output logic            carry_out
);

    localparam int MSB = rsse_pkg::RSSE_BYTE_W - 1;

    always_comb begin
        if (dir_right) begin
            data_out  = {(through ? carry_in : data_in[0]), data_in[MSB:1]};
            carry_out = through ? data_in[0] : carry_in;
        end else begin
            data_out  = {data_in[MSB-1:0], (through ? carry_in : data_in[MSB])};
            carry_out = through ? data_in[MSB] : carry_in;
        end
    end

endmodule

// [core/rsse_subtractor.sv]
`timescale 1ns/10ps
module rsse_subtractor (
    // Operands
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    input  wire logic       borrow_in,
    // Result and flags
    output logic [7:0]      diff,
    output logic            no_borrow,
    output logic            half_no_borrow,
    output logic            signed_wrap,
    output logic            is_zero
);

    localparam int NW = rsse_pkg::RSSE_NIB_W;
    localparam int BW = rsse_pkg::RSSE_BYTE_W;

    logic [BW:0] full;
    logic [NW:0] low;

    always_comb begin
        full           = {1'b0, minuend} - {1'b0, subtrahend} - {{BW{1'b0}}, borrow_in};
        low            = {1'b0, minuend[NW-1:0]} - {1'b0, subtrahend[NW-1:0]} - {{NW{1'b0}}, borrow_in};
        diff           = full[BW-1:0];
        no_borrow      = ~full[BW];
        half_no_borrow = ~low[NW];
        signed_wrap    = (minuend[BW-1] ^ subtrahend[BW-1]) & (minuend[BW-1] ^ full[BW-1]);
        is_zero        = (full[BW-1:0] == rsse_pkg::RSSE_ZERO_BYTE);
    end

endmodule

// [core/rsse_exec.sv]
// Function
// - Pop-load-literal pops the return address, loads the literal, keeps every flag.
// - Interrupt exit pops the return address and sets the interrupt gate, flags untouched.
// - A pending interrupt at interrupt exit is serviced before resuming at the return address.
// - Rotate left moves bit 7 into bit 0, no flags; work form writes work.
// - All to-work rotate and skip forms leave the memory byte unwritten.
// - Rotate left through flag: old carry into bit 0, bit 7 into carry.
// - Rotate right moves bit 0 into bit 7, no flags; work form writes work.
// - Rotate right through flag: old carry into bit 7, bit 0 into carry.
// - Minus with borrow is work minus byte minus inverted carry; all four flags.
// - Every subtract clears carry on a negative result and sets it otherwise.
// - Plain minus subtracts a byte or literal without borrow; all four flags updated.
// - Decrement skip writes byte minus one back, skips on zero, no flags.
// - To-work decrement and increment skip write only work and skip on zero.
// - Increment skip writes byte plus one back, skips on zero, no flags.
// - Every conditional skip takes two cycles with a dummy slot.
// - Skip-bit-high skips when the selected bit is one, no flags.
// - Set byte writes all ones to memory, flags unchanged.
// - Set bit forces only the selected bit to one, flags unchanged.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
module rsse_exec (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               reset,
    // Instruction issue from the decoder
    input  wire logic               op_valid,
    input  wire rsse_pkg::rsse_op_e op_code,
    input  wire logic [2:0]         op_bit_sel,
    input  wire logic [7:0]         op_literal,
    input  wire logic [7:0]         mem_rdata,
    output logic                    op_ready,
    output logic                    op_done,
    // Interrupt control
    input  wire logic               irq_pending,
    input  wire logic               gate_clear,
    output logic                    global_irq_gate,
    output logic                    irq_service,
    // Data memory write port
    output logic                    mem_wr_en,
    output logic [7:0]              mem_wdata,
    // Program flow
    output logic                    stack_pop,
    output logic                    skip_next,
    // Work register and status flags
    output logic [7:0]              work_register,
    output logic                    carry_flag,
    output logic                    zero_flag,
    output logic                    half_borrow_flag,
    output logic                    signed_wrap_flag
);

    typedef struct packed {
        logic [7:0]            work;
        logic                  carry;
        logic                  zero;
        logic                  half;
        logic                  wrap;
        logic                  gate;
        logic                  mem_we;
        logic [7:0]            mem_wdata;
        logic                  pop;
        logic                  skip;
        logic                  irq_take;
        logic                  ready;
        logic                  done;
        rsse_pkg::rsse_phase_e phase;
    } rsse_state_s;

    rsse_state_s st_q;
    rsse_state_s st_d;

    logic       op_take;
    logic       rot_right;
    logic       rot_through;
    logic [7:0] rot_res;
    logic       rot_carry;
    logic       sub_borrow;
    logic [7:0] sub_b;
    logic [7:0] sub_diff;
    logic       sub_nb;
    logic       sub_half;
    logic       sub_wrap;
    logic       sub_zero;
    logic [7:0] dec_val;
    logic [7:0] inc_val;

    assign op_take = op_valid & st_q.ready;

    ////////////////////////////////////////////////////////////////////////////////
    // Shared datapath.

    assign rot_right   = op_code inside {rsse_pkg::OP_ROTATE_RIGHT, rsse_pkg::OP_ROTATE_RIGHT_TO_WORK,
                                         rsse_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG,
                                         rsse_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG_TO_WORK};
    assign rot_through = op_code inside {rsse_pkg::OP_ROTATE_LEFT_THROUGH_FLAG,
                                         rsse_pkg::OP_ROTATE_LEFT_THROUGH_FLAG_TO_WORK,
                                         rsse_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG,
                                         rsse_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG_TO_WORK};

    rsse_rotator u_rotator (
        .data_in   (mem_rdata),
        .carry_in  (st_q.carry),
        .dir_right (rot_right),
        .through   (rot_through),
        .data_out  (rot_res),
        .carry_out (rot_carry)
    );

    // The borrow input is the inverted carry only for the with-borrow forms.
    assign sub_borrow = (op_code inside {rsse_pkg::OP_MINUS_WITH_BORROW,
                                         rsse_pkg::OP_MINUS_WITH_BORROW_TO_MEMORY}) & ~st_q.carry;
    assign sub_b      = (op_code == rsse_pkg::OP_MINUS_LITERAL) ? op_literal : mem_rdata;

    rsse_subtractor u_subtractor (
        .minuend        (st_q.work),
        .subtrahend     (sub_b),
        .borrow_in      (sub_borrow),
        .diff           (sub_diff),
        .no_borrow      (sub_nb),
        .half_no_borrow (sub_half),
        .signed_wrap    (sub_wrap),
        .is_zero        (sub_zero)
    );

    assign dec_val = mem_rdata - rsse_pkg::RSSE_ONE;
    assign inc_val = mem_rdata + rsse_pkg::RSSE_ONE;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        st_d          = st_q;
        st_d.mem_we   = 1'b0;
        st_d.pop      = 1'b0;
        st_d.skip     = 1'b0;
        st_d.irq_take = 1'b0;
        st_d.done     = 1'b0;
        if (gate_clear) begin
            st_d.gate = 1'b0;
        end
        case (st_q.phase)
            rsse_pkg::PH_RUN: begin
                if (op_valid) begin
                    st_d.done = 1'b1;
                    case (op_code)
                        rsse_pkg::OP_POP_LOAD_LITERAL: begin
                            st_d.pop  = 1'b1;
                            st_d.work = op_literal;
                        end
                        rsse_pkg::OP_IRQ_EXIT: begin
                            // Written after the clear so that the set wins a collision.
                            st_d.pop      = 1'b1;
                            st_d.gate     = 1'b1;
                            st_d.irq_take = irq_pending;
                        end
                        rsse_pkg::OP_ROTATE_LEFT, rsse_pkg::OP_ROTATE_RIGHT,
                        rsse_pkg::OP_ROTATE_LEFT_THROUGH_FLAG, rsse_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG: begin
                            st_d.mem_we    = 1'b1;
                            st_d.mem_wdata = rot_res;
                            st_d.carry     = rot_carry;
                        end
                        rsse_pkg::OP_ROTATE_LEFT_TO_WORK, rsse_pkg::OP_ROTATE_RIGHT_TO_WORK,
                        rsse_pkg::OP_ROTATE_LEFT_THROUGH_FLAG_TO_WORK,
                        rsse_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG_TO_WORK: begin
                            st_d.work  = rot_res;
                            st_d.carry = rot_carry;
                        end
                        rsse_pkg::OP_MINUS_WITH_BORROW, rsse_pkg::OP_MINUS, rsse_pkg::OP_MINUS_LITERAL,
                        rsse_pkg::OP_MINUS_WITH_BORROW_TO_MEMORY, rsse_pkg::OP_MINUS_TO_MEMORY: begin
                            if (op_code inside {rsse_pkg::OP_MINUS_WITH_BORROW_TO_MEMORY,
                                                rsse_pkg::OP_MINUS_TO_MEMORY}) begin
                                st_d.mem_we    = 1'b1;
                                st_d.mem_wdata = sub_diff;
                            end else begin
                                st_d.work = sub_diff;
                            end
                            st_d.carry = sub_nb;
                            st_d.zero  = sub_zero;
                            st_d.half  = sub_half;
                            st_d.wrap  = sub_wrap;
                        end
                        rsse_pkg::OP_DECREMENT_SKIP_ZERO: begin
                            st_d.mem_we    = 1'b1;
                            st_d.mem_wdata = dec_val;
                            st_d.skip      = (dec_val == rsse_pkg::RSSE_ZERO_BYTE);
                            st_d.phase     = rsse_pkg::PH_DUMMY;
                        end
                        rsse_pkg::OP_INCREMENT_SKIP_ZERO: begin
                            st_d.mem_we    = 1'b1;
                            st_d.mem_wdata = inc_val;
                            st_d.skip      = (inc_val == rsse_pkg::RSSE_ZERO_BYTE);
                            st_d.phase     = rsse_pkg::PH_DUMMY;
                        end
                        rsse_pkg::OP_DECREMENT_SKIP_ZERO_TO_WORK: begin
                            st_d.work  = dec_val;
                            st_d.skip  = (dec_val == rsse_pkg::RSSE_ZERO_BYTE);
                            st_d.phase = rsse_pkg::PH_DUMMY;
                        end
                        rsse_pkg::OP_INCREMENT_SKIP_ZERO_TO_WORK: begin
                            st_d.work  = inc_val;
                            st_d.skip  = (inc_val == rsse_pkg::RSSE_ZERO_BYTE);
                            st_d.phase = rsse_pkg::PH_DUMMY;
                        end
                        rsse_pkg::OP_SKIP_BIT_HIGH: begin
                            st_d.skip  = mem_rdata[op_bit_sel];
                            st_d.phase = rsse_pkg::PH_DUMMY;
                        end
                        rsse_pkg::OP_SET_BYTE: begin
                            st_d.mem_we    = 1'b1;
                            st_d.mem_wdata = rsse_pkg::RSSE_ALL_ONES;
                        end
                        rsse_pkg::OP_SET_BIT: begin
                            st_d.mem_we    = 1'b1;
                            st_d.mem_wdata = mem_rdata | (rsse_pkg::RSSE_ONE << op_bit_sel);
                        end
                        default: begin
                        end
                    endcase
                end
            end
            rsse_pkg::PH_DUMMY: begin
                // The dummy slot lets the fetch unit drop or fetch the next word.
                st_d.phase = rsse_pkg::PH_RUN;
            end
            default: begin
                st_d.phase = rsse_pkg::PH_RUN;
            end
        endcase
        st_d.ready = (st_d.phase == rsse_pkg::PH_RUN);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q           <= '0;
            st_q.work      <= rsse_pkg::RSSE_WORK_RESET;
            st_q.carry     <= rsse_pkg::RSSE_FLAG_RESET;
            st_q.zero      <= rsse_pkg::RSSE_FLAG_RESET;
            st_q.half      <= rsse_pkg::RSSE_FLAG_RESET;
            st_q.wrap      <= rsse_pkg::RSSE_FLAG_RESET;
            st_q.gate      <= rsse_pkg::RSSE_GATE_RESET;
            st_q.ready     <= 1'b1;
            st_q.phase     <= rsse_pkg::PH_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    assign op_ready         = st_q.ready;
    assign op_done          = st_q.done;
    assign global_irq_gate  = st_q.gate;
    assign irq_service      = st_q.irq_take;
    assign mem_wr_en        = st_q.mem_we;
    assign mem_wdata        = st_q.mem_wdata;
    assign stack_pop        = st_q.pop;
    assign skip_next        = st_q.skip;
    assign work_register    = st_q.work;
    assign carry_flag       = st_q.carry;
    assign zero_flag        = st_q.zero;
    assign half_borrow_flag = st_q.half;
    assign signed_wrap_flag = st_q.wrap;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [7:0] h_rol;
    logic [7:0] h_ror;
    logic [7:0] h_rlc;
    logic [7:0] h_rrc;
    logic [7:0] h_diff;
    logic [7:0] h_bit;
    logic       h_nb;
    logic       h_sel;
    logic [3:0] h_flags;

    assign h_rol   = {mem_rdata[6:0], mem_rdata[7]};
    assign h_ror   = {mem_rdata[0], mem_rdata[7:1]};
    assign h_rlc   = {mem_rdata[6:0], carry_flag};
    assign h_rrc   = {carry_flag, mem_rdata[7:1]};
    assign h_diff  = work_register - sub_b - {7'h00, sub_borrow};
    assign h_nb    = ({1'b0, work_register} >= ({1'b0, sub_b} + {8'h00, sub_borrow}));
    assign h_bit   = mem_rdata | (8'h01 << op_bit_sel);
    assign h_sel   = mem_rdata[op_bit_sel];
    assign h_flags = {carry_flag, zero_flag, half_borrow_flag, signed_wrap_flag};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    pop_literal_a: assert property (op_take && op_code == rsse_pkg::OP_POP_LOAD_LITERAL |=>
        stack_pop && work_register == $past(op_literal) && $stable(h_flags)) else $error("pop literal wrong");
    irq_exit_a: assert property (op_take && op_code == rsse_pkg::OP_IRQ_EXIT |=>
        stack_pop && global_irq_gate && $stable(h_flags)) else $error("irq exit wrong");
    irq_service_a: assert property (op_take && op_code == rsse_pkg::OP_IRQ_EXIT |=>
        irq_service == $past(irq_pending)) else $error("pending irq not serviced");
    rotate_left_a: assert property (op_take && op_code == rsse_pkg::OP_ROTATE_LEFT |=>
        mem_wr_en && mem_wdata == $past(h_rol) && $stable(h_flags)) else $error("rotate left wrong");
    work_no_write_a: assert property (op_take && op_code inside {rsse_pkg::OP_ROTATE_LEFT_TO_WORK,
        rsse_pkg::OP_ROTATE_RIGHT_TO_WORK, rsse_pkg::OP_ROTATE_LEFT_THROUGH_FLAG_TO_WORK,
        rsse_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG_TO_WORK, rsse_pkg::OP_DECREMENT_SKIP_ZERO_TO_WORK,
        rsse_pkg::OP_INCREMENT_SKIP_ZERO_TO_WORK} |=> !mem_wr_en) else $error("work form wrote memory");
    rotate_lflag_a: assert property (op_take && op_code == rsse_pkg::OP_ROTATE_LEFT_THROUGH_FLAG_TO_WORK |=>
        work_register == $past(h_rlc) && carry_flag == $past(mem_rdata[7])) else $error("rlc wrong");
    rotate_right_a: assert property (op_take && op_code == rsse_pkg::OP_ROTATE_RIGHT_TO_WORK |=>
        work_register == $past(h_ror) && $stable(h_flags)) else $error("rotate right wrong");
    rotate_rflag_a: assert property (op_take && op_code == rsse_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG |=>
        mem_wdata == $past(h_rrc) && carry_flag == $past(mem_rdata[0])) else $error("rrc wrong");
    minus_borrow_a: assert property (op_take && op_code == rsse_pkg::OP_MINUS_WITH_BORROW |=>
        work_register == $past(h_diff)) else $error("minus with borrow wrong");
    minus_carry_a: assert property (op_take && op_code inside {rsse_pkg::OP_MINUS,
        rsse_pkg::OP_MINUS_TO_MEMORY, rsse_pkg::OP_MINUS_LITERAL, rsse_pkg::OP_MINUS_WITH_BORROW,
        rsse_pkg::OP_MINUS_WITH_BORROW_TO_MEMORY} |=> carry_flag == $past(h_nb)) else $error("carry wrong");
    minus_memory_a: assert property (op_take && op_code == rsse_pkg::OP_MINUS_TO_MEMORY |=>
        mem_wr_en && mem_wdata == $past(h_diff) && $stable(work_register)) else $error("minus to memory wrong");
    dec_skip_a: assert property (op_take && op_code == rsse_pkg::OP_DECREMENT_SKIP_ZERO && mem_rdata == 8'h01
        |=> mem_wr_en && mem_wdata == 8'h00 && skip_next && $stable(h_flags)) else $error("dec skip wrong");
    inc_work_a: assert property (op_take && op_code == rsse_pkg::OP_INCREMENT_SKIP_ZERO_TO_WORK
        |=> skip_next == (work_register == 8'h00)) else $error("inc work skip wrong");
    inc_skip_a: assert property (op_take && op_code == rsse_pkg::OP_INCREMENT_SKIP_ZERO && mem_rdata == 8'hFF
        |=> mem_wr_en && mem_wdata == 8'h00 && skip_next) else $error("inc skip wrong");
    skip_slot_a: assert property (op_take && op_code inside {rsse_pkg::OP_DECREMENT_SKIP_ZERO,
        rsse_pkg::OP_DECREMENT_SKIP_ZERO_TO_WORK, rsse_pkg::OP_INCREMENT_SKIP_ZERO,
        rsse_pkg::OP_INCREMENT_SKIP_ZERO_TO_WORK, rsse_pkg::OP_SKIP_BIT_HIGH}
        |=> !op_ready ##1 op_ready && !op_done) else $error("skip not two cycles");
    bit_skip_a: assert property (op_take && op_code == rsse_pkg::OP_SKIP_BIT_HIGH |=>
        skip_next == $past(h_sel) && !mem_wr_en) else $error("bit skip wrong");
    set_byte_a: assert property (op_take && op_code == rsse_pkg::OP_SET_BYTE |=>
        mem_wr_en && mem_wdata == 8'hFF && $stable(h_flags)) else $error("set byte wrong");
    set_bit_a: assert property (op_take && op_code == rsse_pkg::OP_SET_BIT |=>
        mem_wdata == $past(h_bit) && $stable(h_flags)) else $error("set bit wrong");
    zero_flag_a: assert property (op_take && op_code == rsse_pkg::OP_MINUS_LITERAL |=>
        zero_flag == (work_register == 8'h00)) else $error("zero flag wrong");
    half_flag_a: assert property (op_take && op_code == rsse_pkg::OP_MINUS_LITERAL |=>
        half_borrow_flag == ($past(work_register[3:0]) >= $past(op_literal[3:0]))) else $error("half flag wrong");
    // A request offered while the dummy slot runs must leave no trace at all.
    refused_op_a: assert property (!op_ready |=> !op_done && !mem_wr_en && !stack_pop && !skip_next)
        else $error("op taken in dummy slot");
    gate_collide_a: assert property (op_take && op_code == rsse_pkg::OP_IRQ_EXIT && gate_clear |=>
        global_irq_gate) else $error("gate clear beat irq exit");

    skip_taken_c: cover property (op_take && op_code == rsse_pkg::OP_DECREMENT_SKIP_ZERO ##1 skip_next);
    irq_pend_c: cover property (op_take && op_code == rsse_pkg::OP_IRQ_EXIT && irq_pending);
    borrow_neg_c: cover property (op_take && op_code == rsse_pkg::OP_MINUS_WITH_BORROW ##1 !carry_flag);
    gate_collide_c: cover property (op_take && op_code == rsse_pkg::OP_IRQ_EXIT && gate_clear);
    refused_op_c: cover property (op_valid && !op_ready);

endmodule

// [bench/rsse_far_model.sv]
`timescale 1ns/10ps
// Data memory and return stack seen by the block: one byte cell and a pop counter.
module rsse_far_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Preload from the bench
    input  wire logic       load_en,
    input  wire logic [7:0] load_val,
    // Design side
    input  wire logic       mem_wr_en,
    input  wire logic [7:0] mem_wdata,
    input  wire logic       stack_pop,
    output logic      [7:0] mem_rdata,
    output logic      [7:0] pop_cnt
);
    // Apart from a bench preload, the cell only changes on a real write, so a to-work form that writes shows up.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mem_rdata <= 8'h00;
            pop_cnt   <= 8'h00;
        end else begin
            if (load_en) begin
                mem_rdata <= load_val;
            end else if (mem_wr_en) begin
                mem_rdata <= mem_wdata;
            end
            pop_cnt <= pop_cnt + {7'h00, stack_pop};
        end
    end
endmodule

// [bench/rsse_exec_test.sv]
`timescale 1ns/10ps
module rsse_exec_test;
    logic               sys_clk, reset, op_valid, irq_pending, gate_clear, load_en;
    rsse_pkg::rsse_op_e op_code;
    logic [2:0]         op_bit_sel;
    logic [7:0]         op_literal, load_val, mem_rdata, pop_cnt, work_register, mem_wdata;
    logic               op_ready, op_done, global_irq_gate, irq_service, mem_wr_en, stack_pop, skip_next;
    logic               carry_flag, zero_flag, half_borrow_flag, signed_wrap_flag;
    int                 error_cnt, compares;
    // Row: op, literal, memory byte, bit, work after, memory after, skip, flags {carry,zero,half,wrap}.
    // Rows run in order; each one starts from the work register and flags the row before it left.
    logic [51:0]        rows [22] = '{52'h01_5A_00_0_5A_00_0_0, 52'h03_00_81_0_5A_03_0_0, 52'h04_00_81_0_03_81_0_0,
        52'h07_00_01_0_03_80_0_0, 52'h08_00_01_0_80_01_0_0, 52'h05_00_80_0_80_00_0_8, 52'h06_00_00_0_01_00_0_0,
        52'h09_00_01_0_01_00_0_8, 52'h0A_00_00_0_80_00_0_0, 52'h0D_00_01_0_7F_01_0_9, 52'h0B_00_80_0_FF_80_0_3,
        52'h0C_00_FE_0_FF_00_0_E, 52'h0E_00_0F_0_FF_F0_0_A, 52'h0F_FF_00_0_00_00_0_E, 52'h10_00_01_0_00_00_1_E,
        52'h11_00_05_0_04_05_0_E, 52'h12_00_FF_0_04_00_1_E, 52'h13_00_FF_0_00_FF_1_E, 52'h14_00_10_4_00_10_1_E,
        52'h14_00_EF_4_00_EF_0_E, 52'h15_00_12_0_00_FF_0_E, 52'h16_00_00_7_00_80_0_E};

    rsse_exec u_rsse_exec (.sys_clk(sys_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
        .op_bit_sel(op_bit_sel), .op_literal(op_literal), .mem_rdata(mem_rdata), .op_ready(op_ready),
        .op_done(op_done), .irq_pending(irq_pending), .gate_clear(gate_clear), .global_irq_gate(global_irq_gate),
        .irq_service(irq_service), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .stack_pop(stack_pop),
        .skip_next(skip_next), .work_register(work_register), .carry_flag(carry_flag), .zero_flag(zero_flag),
        .half_borrow_flag(half_borrow_flag), .signed_wrap_flag(signed_wrap_flag));
    rsse_far_model u_rsse_far_model (.sys_clk(sys_clk), .reset(reset), .load_en(load_en), .load_val(load_val),
        .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .stack_pop(stack_pop), .mem_rdata(mem_rdata), .pop_cnt(pop_cnt));

    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        compares++;
        if (seen !== expd) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Preload the memory cell, then present one op for one cycle; returns just after the taking edge.
    task automatic issue(input logic [7:0] op, input logic [7:0] lit, input logic [7:0] rd, input logic [3:0] bs);
        @(posedge sys_clk);
        load_en  <= 1'b1;
        load_val <= rd;
        @(posedge sys_clk);
        load_en    <= 1'b0;
        op_valid   <= 1'b1;
        op_code    <= rsse_pkg::rsse_op_e'(op[4:0]);
        op_literal <= lit;
        op_bit_sel <= bs[2:0];
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Fixed-latency block, so a hang can only mean a broken bench; cut it short anyway.
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        {reset, op_valid, irq_pending, gate_clear, load_en, op_bit_sel, op_literal, load_val} = {5'h10, 3'h0, 16'h0000};
        op_code = rsse_pkg::OP_NOP;
        error_cnt = 0;
        compares = 0;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        check({work_register[6:0], op_ready}, 8'h01);
        foreach (rows[i]) begin
            issue(rows[i][51:44], rows[i][43:36], rows[i][35:28], rows[i][27:24]);
            check({6'h00, op_done, skip_next}, {7'h01, rows[i][4]});
            check({7'h00, op_ready}, {7'h00, !(rows[i][51:44] inside {[8'h10:8'h14]})});
            check(work_register, rows[i][23:16]);
            check({4'h0, carry_flag, zero_flag, half_borrow_flag, signed_wrap_flag}, {4'h0, rows[i][3:0]});
            @(posedge sys_clk);
            #1;
            check(mem_rdata, rows[i][15:8]);
        end
        // A request during the dummy slot must vanish without a trace.
        issue(8'h10, 8'h00, 8'h05, 4'h0);
        op_valid   <= 1'b1;
        op_code    <= rsse_pkg::OP_POP_LOAD_LITERAL;
        op_literal <= 8'h33;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
        check(work_register, 8'h00);
        check(mem_rdata, 8'h04);
        irq_pending <= 1'b1;
        issue(8'h02, 8'h00, 8'h00, 4'h0);
        check({5'h00, stack_pop, irq_service, global_irq_gate}, 8'h07);
        check({4'h0, carry_flag, zero_flag, half_borrow_flag, signed_wrap_flag}, 8'h0E);
        @(posedge sys_clk);
        gate_clear  <= 1'b1;
        irq_pending <= 1'b0;
        @(posedge sys_clk);
        #1;
        check({7'h00, global_irq_gate}, 8'h00);
        // The clear stays high through the next exit, so the set has to win the collision.
        issue(8'h02, 8'h00, 8'h00, 4'h0);
        check({5'h00, stack_pop, irq_service, global_irq_gate}, 8'h05);
        @(posedge sys_clk);
        gate_clear <= 1'b0;
        #1;
        check({7'h00, global_irq_gate}, 8'h00);
        check(pop_cnt, 8'h03);
        tally_and_finish();
    end
endmodule
